// ===== src/fdc_pkg.sv
// Package for the fieldbus drive control word translator.
// Assumes one 25 MHz clock and a plain register port.
package fdc_pkg;
	localparam int FDC_WORD_W = 16;
	localparam int FDC_ADDR_W = 4;
	// Register offsets
	localparam logic [3:0] FDC_OFF_CTRL = 4'h0;
	localparam logic [3:0] FDC_OFF_STAT = 4'h1;
	localparam logic [3:0] FDC_OFF_MODE = 4'h2;
	// Reset values; the control word resets to a safe stop with reserved ones held
	localparam logic [15:0] FDC_CTRL_RST = 16'h047E;
	localparam logic [15:0] FDC_MODE_RST = 16'h0000;
	localparam logic [15:0] FDC_UNMAPPED = 16'h0000;
	// Command bit positions
	localparam int FDC_CB_SWITCH_ON = 0;
	localparam int FDC_CB_COAST = 1;
	localparam int FDC_CB_FAST = 2;
	localparam int FDC_CB_ENABLE = 3;
	localparam int FDC_CB_FAULT_CLR = 7;
	// Status bit positions
	localparam int FDC_SB_SWON_EN = 0;
	localparam int FDC_SB_SWITCHED = 1;
	localparam int FDC_SB_RUNNING = 2;
	localparam int FDC_SB_FAULT = 3;
	localparam int FDC_SB_COAST = 4;
	localparam int FDC_SB_FAST = 5;
	localparam int FDC_SB_START_DIS = 6;
	localparam int FDC_SB_REMOTE = 9;
	localparam int FDC_SB_AT_SPEED = 10;
	localparam int FDC_SB_LIMIT = 11;
	// Mode register bit positions
	localparam int FDC_MB_REMOTE = 0;
	localparam int FDC_MB_COMMS_SEL = 1;
	// Sequencer state codes
	localparam logic [2:0] FDC_SEQ_START_DISABLED = 3'h0;
	localparam logic [2:0] FDC_SEQ_TRIPPED = 3'h7;
endpackage

// ===== src/fdc_status_word.sv
// Assembles the drive status word from sequencer and ramp conditions.
// Assumes all inputs are synchronous to the caller's clock; output is combinational.
`timescale 1ns/1ps
module fdc_status_word
	import fdc_pkg::*;
(
	// Sequencer outputs
	input wire logic swon_enable,
	input wire logic switched_on,
	input wire logic running,
	input wire logic tripped,
	input wire logic [2:0] seq_state,
	// Stop release sources
	input wire logic comms_mode,
	input wire logic cmd_coast,
	input wire logic cmd_fast,
	input wire logic loc_coast,
	input wire logic loc_fast,
	// Mode and ramp conditions
	input wire logic remote_mode,
	input wire logic comms_sel,
	input wire logic ramping,
	input wire logic vector_mode,
	input wire logic torque_limit,
	input wire logic current_limit,
	// Result
	output logic [15:0] status
);
	always_comb
	begin
		// Unsupported bits stay zero
		status = 16'h0000;
		status[FDC_SB_SWON_EN] = swon_enable;
		status[FDC_SB_SWITCHED] = switched_on;
		status[FDC_SB_RUNNING] = running;
		status[FDC_SB_FAULT] = tripped;
		status[FDC_SB_COAST] = comms_mode ? cmd_coast : loc_coast;
		status[FDC_SB_FAST] = comms_mode ? cmd_fast : loc_fast;
		status[FDC_SB_START_DIS] = (seq_state == FDC_SEQ_START_DISABLED);
		status[FDC_SB_REMOTE] = remote_mode & comms_sel;
		status[FDC_SB_AT_SPEED] = ~ramping;
		status[FDC_SB_LIMIT] = vector_mode ? torque_limit : current_limit;
	end
endmodule

// ===== src/fdc_control_word.sv
// Fieldbus drive control word translator: register port, command decode, status word.
// Assumes a remote master writes the command word; the sequencer sits outside.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module fdc_control_word
	import fdc_pkg::*;
#(
	parameter int WORD_W = FDC_WORD_W
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Local sequencing inputs
	input wire logic loc_forward_run,
	input wire logic loc_reverse_run,
	input wire logic loc_stop_release,
	input wire logic loc_fault_clear,
	input wire logic loc_coast_release,
	input wire logic loc_fast_release,
	input wire logic loc_enable,
	// Sequencer feedback
	input wire logic seq_swon_enable,
	input wire logic seq_switched_on,
	input wire logic seq_running,
	input wire logic seq_tripped,
	input wire logic [2:0] seq_state,
	// Ramp and limit conditions
	input wire logic ramp_active,
	input wire logic vector_mode,
	input wire logic torque_limit,
	input wire logic current_limit,
	// Sequencer inputs
	output logic forward_run_input,
	output logic reverse_run_input,
	output logic stop_release_input,
	output logic coast_release_input,
	output logic fast_release_input,
	output logic enable_input,
	output logic remote_fault_clear_input,
	// Status
	output logic [15:0] drive_status_out,
	output logic comms_mode
);
	// The ports are fixed at 16 bits, so any other width is refused here
	if (WORD_W != 16)
	begin : g_word_w_check
		$error("fdc_control_word: only a 16-bit word is supported");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] drive_control_word;
		logic [15:0] mode;
		logic [15:0] rdata;
		logic forward_run;
		logic reverse_run;
		logic stop_release;
		logic coast_release;
		logic fast_release;
		logic enable;
		logic fault_clear;
		logic [15:0] status;
	} fdc_state_s;

	fdc_state_s st;
	fdc_state_s next_st;
	logic [15:0] status_now;
	logic remote_sel;

	assign remote_sel = st.mode[FDC_MB_REMOTE] & st.mode[FDC_MB_COMMS_SEL];

	// ----------------------------------------
	// Status word assembly
	// ----------------------------------------
	fdc_status_word u_status (
		.swon_enable(seq_swon_enable),
		.switched_on(seq_switched_on),
		.running(seq_running),
		.tripped(seq_tripped),
		.seq_state(seq_state),
		.comms_mode(remote_sel),
		.cmd_coast(st.drive_control_word[FDC_CB_COAST]),
		.cmd_fast(st.drive_control_word[FDC_CB_FAST]),
		.loc_coast(loc_coast_release),
		.loc_fast(loc_fast_release),
		.remote_mode(st.mode[FDC_MB_REMOTE]),
		.comms_sel(st.mode[FDC_MB_COMMS_SEL]),
		.ramping(ramp_active),
		.vector_mode(vector_mode),
		.torque_limit(torque_limit),
		.current_limit(current_limit),
		.status(status_now)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.rdata = FDC_UNMAPPED;
		// Bits 4-6, 10 and the rest are stored but never acted on
		if (wr)
		begin
			if (addr == FDC_OFF_CTRL)
				next_st.drive_control_word = wdata;
			// Only the remote and comms-select bits are kept
			else if (addr == FDC_OFF_MODE)
				next_st.mode = {14'h0000, wdata[1:0]};
		end
		if (rd)
		begin
			if (addr == FDC_OFF_CTRL)
				next_st.rdata = st.drive_control_word;
			else if (addr == FDC_OFF_STAT)
				next_st.rdata = st.status;
			else if (addr == FDC_OFF_MODE)
				next_st.rdata = st.mode;
			else
				next_st.rdata = FDC_UNMAPPED;
		end
		// One-cycle decode delay keeps all sequencer inputs glitch free
		if (remote_sel)
		begin
			// Command word replaces local run and stop release; coast, fast and enable AND it with the local source
			next_st.forward_run = st.drive_control_word[FDC_CB_SWITCH_ON];
			next_st.reverse_run = 1'b0;
			next_st.stop_release = 1'b0;
			next_st.coast_release = st.drive_control_word[FDC_CB_COAST]
				& loc_coast_release;
			next_st.fast_release = st.drive_control_word[FDC_CB_FAST]
				& loc_fast_release;
			next_st.enable = st.drive_control_word[FDC_CB_ENABLE] & loc_enable;
			// Sequencer acts on the rise
			next_st.fault_clear = st.drive_control_word[FDC_CB_FAULT_CLR];
		end
		else
		begin
			next_st.forward_run = loc_forward_run;
			next_st.reverse_run = loc_reverse_run;
			next_st.stop_release = loc_stop_release;
			next_st.coast_release = loc_coast_release;
			next_st.fast_release = loc_fast_release;
			next_st.enable = loc_enable;
			next_st.fault_clear = loc_fault_clear;
		end
		next_st.status = status_now;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			st.drive_control_word <= FDC_CTRL_RST;
			st.mode <= FDC_MODE_RST;
			st.rdata <= 16'h0000;
			st.forward_run <= 1'b0;
			st.reverse_run <= 1'b0;
			st.stop_release <= 1'b0;
			st.coast_release <= 1'b0;
			st.fast_release <= 1'b0;
			st.enable <= 1'b0;
			st.fault_clear <= 1'b0;
			st.status <= 16'h0000;
		end
		else
			st <= next_st;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata = st.rdata;
	assign forward_run_input = st.forward_run;
	assign reverse_run_input = st.reverse_run;
	assign stop_release_input = st.stop_release;
	assign coast_release_input = st.coast_release;
	assign fast_release_input = st.fast_release;
	assign enable_input = st.enable;
	assign remote_fault_clear_input = st.fault_clear;
	assign drive_status_out = st.status;
	assign comms_mode = remote_sel;

	// ----------------------------------------
	// Checks on the sequencer inputs
	// ----------------------------------------
	// Each check looks one edge back; the edge that leaves reset has no valid past
	a_run_follows_bit: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(remote_sel) |->
		forward_run_input == $past(st.drive_control_word[0])
		&& !reverse_run_input && !stop_release_input)
		else $error("run inputs do not follow command bit 0");

	// The reset value is the stop command, so a fresh remote select never runs
	a_stop_word: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(remote_sel) && $past(st.drive_control_word) == FDC_CTRL_RST
		|-> !forward_run_input)
		else $error("stop command leaves forward run set");

	a_coast_and_gate: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(remote_sel) |-> coast_release_input ==
		($past(st.drive_control_word[1]) & $past(loc_coast_release)))
		else $error("coast release is not the AND of both sources");

	a_fast_and_gate: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(remote_sel) |-> fast_release_input ==
		($past(st.drive_control_word[2]) & $past(loc_fast_release)))
		else $error("fast release is not the AND of both sources");

	a_enable_and_gate: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(remote_sel) && !$past(loc_enable) |-> !enable_input)
		else $error("enable passed while local enable low");

	a_enable_follows: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(remote_sel) |-> enable_input ==
		($past(st.drive_control_word[3]) & $past(loc_enable)))
		else $error("enable is not the AND of both sources");

	// The sequencer finds the rise itself, so the level must pass unchanged
	a_fault_clear_direct: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(remote_sel) |->
		remote_fault_clear_input == $past(st.drive_control_word[7]))
		else $error("fault clear does not follow command bit 7");

	a_fault_clear_rise: assert property (@(posedge clock) disable iff (!nrst)
		remote_sel && $rose(st.drive_control_word[7]) && $stable(remote_sel)
		|=> remote_fault_clear_input)
		else $error("fault clear rise not passed on");

	// Outside comms mode the local sources reach the sequencer one edge later
	a_local_pass: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && !$past(remote_sel) |->
		forward_run_input == $past(loc_forward_run)
		&& reverse_run_input == $past(loc_reverse_run)
		&& stop_release_input == $past(loc_stop_release)
		&& coast_release_input == $past(loc_coast_release)
		&& fast_release_input == $past(loc_fast_release)
		&& enable_input == $past(loc_enable)
		&& remote_fault_clear_input == $past(loc_fault_clear))
		else $error("local sources not passed outside comms mode");

	// ----------------------------------------
	// Checks on the status word
	// ----------------------------------------
	a_status_reserved: assert property (@(posedge clock) disable iff (!nrst)
		drive_status_out[8:7] == 2'b00 && drive_status_out[15:12] == 4'h0)
		else $error("unsupported status bits not zero");

	a_status_mirror: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[3:0] == {$past(seq_tripped), $past(seq_running),
		$past(seq_switched_on), $past(seq_swon_enable)})
		else $error("status bits 0 to 3 do not mirror the sequencer");

	a_switched_flag: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[FDC_SB_SWITCHED] == $past(seq_switched_on))
		else $error("switched on flag wrong");

	a_running_flag: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[FDC_SB_RUNNING] == $past(seq_running))
		else $error("running flag wrong");

	a_fault_flag: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[FDC_SB_FAULT] == $past(seq_tripped))
		else $error("fault flag wrong");

	a_coast_flag: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[FDC_SB_COAST] == ($past(remote_sel)
		? $past(st.drive_control_word[1]) : $past(loc_coast_release)))
		else $error("coast release flag shows the wrong source");

	a_fast_flag: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[FDC_SB_FAST] == ($past(remote_sel)
		? $past(st.drive_control_word[2]) : $past(loc_fast_release)))
		else $error("fast release flag shows the wrong source");

	a_start_disabled: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[6] == ($past(seq_state) == FDC_SEQ_START_DISABLED))
		else $error("start disabled flag wrong");

	a_remote_flag: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[9] == $past(remote_sel))
		else $error("remote status flag wrong");

	a_at_speed: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[10] == !$past(ramp_active))
		else $error("setpoint reached flag wrong");

	a_limit_flag: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) |-> drive_status_out[FDC_SB_LIMIT] == ($past(vector_mode)
		? $past(torque_limit) : $past(current_limit)))
		else $error("internal limit flag wrong");

	// ----------------------------------------
	// Checks on the register port
	// ----------------------------------------
	a_ctrl_write: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(wr) && $past(addr) == FDC_OFF_CTRL |->
		st.drive_control_word == $past(wdata))
		else $error("command word does not hold the written value");

	a_mode_write: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(wr) && $past(addr) == FDC_OFF_MODE |->
		st.mode == {14'h0000, $past(wdata[1:0])})
		else $error("mode register keeps more than its two bits");

	// Read data stand for one cycle only, so a stale word is never seen twice
	a_status_read: assert property (@(posedge clock) disable iff (!nrst)
		$past(nrst) && $past(rd) && $past(addr) == FDC_OFF_STAT |->
		rdata == $past(st.status))
		else $error("status read does not return the status word");
endmodule

// ===== dv/fdc_seq_model.sv
// Behavioural sequencer flags for each sequencer state code.
// Assumes the bench drives the state code; flags follow it with no delay.
`timescale 1ns/1ps
module fdc_seq_model
	import fdc_pkg::*;
(
	// State in
	input wire logic [2:0] state,
	// Flags out
	output logic swon_enable,
	output logic switched_on,
	output logic running,
	output logic tripped
);
	// Codes 0..7 run from start disabled to tripped
	always_comb
	begin
		swon_enable = (state >= 3'h1) && (state <= 3'h6);
		switched_on = (state >= 3'h2) && (state <= 3'h6);
		running = (state == 3'h4);
		tripped = (state >= 3'h6);
	end
endmodule

// ===== dv/fieldbus_drive_control_word_tb.sv
// Self-checking bench for the control word translator.
// Assumes one 25 MHz clock and the plain register port with one-cycle reads.
`timescale 1ns/1ps
module fieldbus_drive_control_word_tb;
	import fdc_pkg::*;
	logic clock, nrst, wr, rd, comms_mode;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, drive_status_out, cw, md, v;
	logic loc_forward_run, loc_reverse_run, loc_stop_release, loc_fault_clear;
	logic loc_coast_release, loc_fast_release, loc_enable;
	logic seq_swon_enable, seq_switched_on, seq_running, seq_tripped;
	logic [2:0] seq_state;
	logic ramp_active, vector_mode, torque_limit, current_limit;
	logic forward_run_input, reverse_run_input, stop_release_input, coast_release_input;
	logic fast_release_input, enable_input, remote_fault_clear_input;
	int n_fail, total_checks;

	fdc_control_word fdc_control_word_inst (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata,
		.loc_forward_run, .loc_reverse_run, .loc_stop_release, .loc_fault_clear,
		.loc_coast_release, .loc_fast_release, .loc_enable, .seq_swon_enable,
		.seq_switched_on, .seq_running, .seq_tripped, .seq_state, .ramp_active,
		.vector_mode, .torque_limit, .current_limit, .forward_run_input,
		.reverse_run_input, .stop_release_input, .coast_release_input, .fast_release_input,
		.enable_input, .remote_fault_clear_input, .drive_status_out, .comms_mode);
	fdc_seq_model fdc_seq_model_inst (.state(seq_state), .swon_enable(seq_swon_enable),
		.switched_on(seq_switched_on), .running(seq_running), .tripped(seq_tripped));

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task rreg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(posedge clock);
		d = rdata;
	endtask

	// Expected outputs from the shadow control word, mode and inputs
	task check_all;
		logic cm;
		logic [15:0] es;
		logic [6:0] eo;
		repeat (2) @(posedge clock);
		#1;
		cm = md[0] & md[1];
		eo = cm ? {cw[0], 2'b00, cw[1] & loc_coast_release, cw[2] & loc_fast_release,
			cw[3] & loc_enable, cw[7]} : {loc_forward_run, loc_reverse_run, loc_stop_release,
			loc_coast_release, loc_fast_release, loc_enable, loc_fault_clear};
		es = 16'h0000;
		es[3:0] = {seq_tripped, seq_running, seq_switched_on, seq_swon_enable};
		es[4] = cm ? cw[1] : loc_coast_release;
		es[5] = cm ? cw[2] : loc_fast_release;
		es[6] = (seq_state == FDC_SEQ_START_DISABLED);
		es[9] = cm;
		es[10] = !ramp_active;
		es[11] = vector_mode ? torque_limit : current_limit;
		chk("seq inputs", {9'h000, eo}, {9'h000, forward_run_input, reverse_run_input,
			stop_release_input, coast_release_input, fast_release_input, enable_input,
			remote_fault_clear_input});
		chk("status", es, drive_status_out);
		chk("comms mode", {15'h0000, cm}, {15'h0000, comms_mode});
		rreg(FDC_OFF_STAT, v);
		chk("status read", es, v);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		rreg(FDC_OFF_CTRL, v);
		chk("ctrl reset", FDC_CTRL_RST, v);
		@(posedge clock);
		#1 chk("rdata idle", 16'h0000, rdata);
		wreg(4'hF, 16'hFFFF);
		rreg(4'hF, v);
		chk("unmapped", FDC_UNMAPPED, v);
		wreg(FDC_OFF_MODE, 16'hFFFD);
		rreg(FDC_OFF_MODE, v);
		chk("mode bits", 16'h0001, v);
		md = 16'h0001;
		check_all();
	endtask

	task t_local;
		wreg(FDC_OFF_MODE, 16'h0000);
		md = 16'h0000;
		for (int i = 0; i < 16; i++)
		begin
			{loc_forward_run, loc_reverse_run, loc_stop_release, loc_coast_release,
				loc_fast_release, loc_enable, loc_fault_clear} <= 7'(i * 9 + 3);
			check_all();
		end
	endtask

	// Sweeps bits 0-3 and 7 against local sources; bits 4-6 and 10 held at one
	task t_remote;
		wreg(FDC_OFF_MODE, 16'h0003);
		md = 16'h0003;
		for (int i = 0; i < 32; i++)
			for (int j = 0; j < 8; j++)
			begin
				cw = {8'h04, i[4], 3'h7, i[3:0]};
				wreg(FDC_OFF_CTRL, cw);
				{loc_forward_run, loc_reverse_run, loc_stop_release, loc_coast_release,
					loc_fast_release, loc_enable, loc_fault_clear} <= 7'(i * 13 + j * 41);
				check_all();
			end
	endtask

	// Mid-run reset: outputs drop at once, registers return to reset values
	task t_reset;
		wreg(FDC_OFF_CTRL, 16'h04FF);
		wreg(FDC_OFF_MODE, 16'h0003);
		@(posedge clock);
		nrst <= 1'b0;
		@(posedge clock);
		#1 chk("reset seq inputs", 16'h0000, {9'h000, forward_run_input, reverse_run_input,
			stop_release_input, coast_release_input, fast_release_input, enable_input,
			remote_fault_clear_input});
		chk("reset status", 16'h0000, drive_status_out);
		chk("reset comms mode", 16'h0000, {15'h0000, comms_mode});
		@(posedge clock);
		nrst <= 1'b1;
		cw = FDC_CTRL_RST;
		md = 16'h0000;
		rreg(FDC_OFF_CTRL, v);
		chk("ctrl after reset", FDC_CTRL_RST, v);
		rreg(FDC_OFF_MODE, v);
		chk("mode after reset", FDC_MODE_RST, v);
		check_all();
	endtask

	task t_status;
		for (int k = 0; k < 64; k++)
		begin
			md = {14'h0000, k[1:0]};
			wreg(FDC_OFF_MODE, md);
			seq_state <= k[4:2];
			ramp_active <= k[5];
			vector_mode <= k[0];
			torque_limit <= k[3];
			current_limit <= ~k[3];
			check_all();
		end
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (30000) @(posedge clock);
		$display("BAD watchdog expected done seen hang");
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		{nrst, wr, rd, addr, wdata, seq_state, ramp_active, vector_mode} = '0;
		{torque_limit, current_limit, loc_forward_run, loc_reverse_run} = '0;
		{loc_stop_release, loc_fault_clear, loc_coast_release, loc_fast_release} = '0;
		loc_enable = 1'b0;
		cw = FDC_CTRL_RST;
		md = 16'h0000;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		t_regs();
		t_local();
		t_remote();
		t_reset();
		t_status();
		tally_and_finish();
	end
endmodule
